// >>> verilog/txd_pkg.sv
// Purpose: constants for the extended transmit data descriptor decoder
// Assumes: 128-bit descriptor, little-endian field packing
// Notes:   register offsets are byte addresses on classic Wishbone
// How it works
// R1: descriptor address field names the host buffer to fetch from.
// R2: length field gives the exact byte count fetched from that buffer.
// R3: host keeps non-segmented packet sum 80 bytes below FIFO allocation.
// R4: type code 0001b marks the extended data descriptor format.
// R5: host writes zero into the reserved descriptor field.
// R6: packet options are taken only from the first descriptor of a packet.
// R7: VLAN tag is taken only from the end-of-packet descriptor.
// R8: command byte bits: delay 7, vlan 6, ext 5, sent 4, report 3, seg 2, fcs 1, end 0.
// R9: format selected only when extension bit and type 0001b are both set.
// R10: status word with done bit 0 written back only when report status set.
// R11: report status with delay reloads timer; without delay, interrupt now and clear.
// R12: VLAN enable inserts Ethertype and tag and forces FCS append.
// R13: descriptors up to and including end of packet form one packet.
package txd_pkg;
	// ---------------------------------------------
	// descriptor field positions
	// ---------------------------------------------
	localparam int ADDR_LSB = 0;
	localparam int LEN_LSB = 64;
	localparam int LEN_W = 20;
	localparam int TYPE_LSB = 84;
	localparam int CMD_LSB = 88;
	localparam int OPTS_LSB = 104;
	localparam int SPECIAL_LSB = 112;
	localparam logic [3:0] TYPE_DATA = 4'h1;
	localparam int CMD_DELAY = 7;
	localparam int CMD_VLAN = 6;
	localparam int CMD_EXT = 5;
	localparam int CMD_SENT = 4;
	localparam int CMD_REPORT = 3;
	localparam int CMD_SEG = 2;
	localparam int CMD_FCS = 1;
	localparam int CMD_END = 0;
	localparam logic [3:0] STATUS_DONE = 4'h1;
	localparam logic [23:0] FIFO_MARGIN = 24'h00_0050;
	// ---------------------------------------------
	// registers
	// ---------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_MASK = 8'h08;
	localparam logic [7:0] REG_DELAY = 8'h0C;
	localparam logic [7:0] REG_FIFO = 8'h10;
	localparam logic [7:0] REG_ETYPE = 8'h14;
	localparam logic [7:0] REG_PKT = 8'h18;
	localparam int INT_DONE = 0;
	localparam int INT_BAD = 1;
	localparam int INT_LEN = 2;
	localparam int INT_PKT = 3;
	localparam logic [19:0] FIFO_RST = 20'h0_4000;
	localparam logic [15:0] ETYPE_RST = 16'h8100;
	localparam logic [15:0] DELAY_RST = 16'h0000;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_FETCH = 2'b01,
		ST_WBACK = 2'b10
	} phase_t;
endpackage

// >>> verilog/desc_fields_if.sv
// Purpose: decoded descriptor fields between unpacker and decoder
// Assumes: single clock, purely combinational contents
// Notes:   is_data qualifies every other field
`timescale 1ns/1ps
interface desc_fields_if;
	logic [63:0] addr;
	logic [19:0] len;
	logic [3:0]  dtype;
	logic [7:0]  cmd;
	logic [7:0]  opts;
	logic [15:0] special;
	logic        is_data;
	modport unpack (output addr, len, dtype, cmd, opts, special, is_data);
	modport user (input addr, len, dtype, cmd, opts, special, is_data);
endinterface

// >>> verilog/desc_unpack.sv
// Purpose: slice a 128-bit descriptor into its fields
// Assumes: descriptor word already in core clock domain
// Notes:   reserved nibble is not checked; host keeps it zero
`timescale 1ns/1ps
module desc_unpack (
	// descriptor
	input  wire logic [127:0] desc_i,
	// fields
	desc_fields_if.unpack     f
);
	assign f.addr    = desc_i[txd_pkg::ADDR_LSB +: 64];
	assign f.len     = desc_i[txd_pkg::LEN_LSB +: txd_pkg::LEN_W];
	assign f.dtype   = desc_i[txd_pkg::TYPE_LSB +: 4];
	assign f.cmd     = desc_i[txd_pkg::CMD_LSB +: 8];
	assign f.opts    = desc_i[txd_pkg::OPTS_LSB +: 8];
	assign f.special = desc_i[txd_pkg::SPECIAL_LSB +: 16];
	// extension bit is descriptor bit 93 [R9]
	assign f.is_data = f.cmd[txd_pkg::CMD_EXT] && (f.dtype == txd_pkg::TYPE_DATA); // [R4]
endmodule

// >>> verilog/delay_timer.sv
// Purpose: transmit interrupt delay countdown
// Assumes: reload in core clock cycles
// Notes:   reload of zero fires on the next cycle
`timescale 1ns/1ps
module delay_timer #(
	parameter int CNT_W = 16
) (
	// clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	// control
	input  wire logic             load_i,
	input  wire logic             clear_i,
	input  wire logic [CNT_W-1:0] reload_i,
	// event
	output logic                  expire_o
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             run;
		logic             fire;
	} tmr_t;
	tmr_t q, d;

	always_comb begin
		d = q;
		d.fire = 1'b0;
		if (clear_i) begin
			d.cnt = '0;
			d.run = 1'b0;
		end else if (load_i) begin
			// reload even while counting [R11]
			d.cnt = reload_i;
			d.run = (reload_i != '0);
			d.fire = (reload_i == '0);
		end else if (q.run) begin
			d.cnt = q.cnt - 1'b1;
			if (q.cnt == {{(CNT_W-1){1'b0}}, 1'b1}) begin
				d.run = 1'b0;
				d.fire = 1'b1;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign expire_o = q.fire;

	a_timer_stop: assert property (@(posedge clk_i) disable iff (rst_i) // [R11]
		clear_i |=> !q.run && !q.fire)
		else $error("timer still running after clear");
endmodule

// >>> verilog/tx_desc_decode.sv
// Purpose: decode extended transmit data descriptors into fetch and status work
// Assumes: fetch, writeback and packet consumers on the core clock
// Notes:   non-data descriptors are consumed and flagged, never fetched
`timescale 1ns/1ps
module tx_desc_decode (
	// clock and reset
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	// wishbone slave
	input  wire logic         wb_cyc_i,
	input  wire logic         wb_stb_i,
	input  wire logic         wb_we_i,
	input  wire logic [7:0]   wb_adr_i,
	input  wire logic [3:0]   wb_sel_i,
	input  wire logic [31:0]  wb_dat_i,
	output logic [31:0]       wb_dat_o,
	output logic              wb_ack_o,
	// descriptor stream
	input  wire logic         desc_valid_i,
	input  wire logic [127:0] desc_data_i,
	output logic              desc_ready_o,
	// buffer fetch request
	output logic              fetch_valid_o,
	output logic [63:0]       fetch_addr_o,
	output logic [19:0]       fetch_len_o,
	input  wire logic         fetch_ready_i,
	// status writeback
	output logic              wback_valid_o,
	output logic [3:0]        wback_status_o,
	input  wire logic         wback_ready_i,
	// packet control
	output logic              pkt_start_o,
	output logic [7:0]        opts_o,
	output logic              pkt_end_o,
	output logic              vlan_insert_o,
	output logic [15:0]       vlan_tag_o,
	output logic [15:0]       vlan_etype_o,
	output logic              append_fcs_o,
	output logic              seg_o,
	// interrupt
	output logic              irq_o
);
	// ---------------------------------------------
	// state
	// ---------------------------------------------
	typedef struct packed {
		txd_pkg::phase_t phase;
		logic            in_pkt;
		logic [7:0]      cmd;
		logic [63:0]     addr;
		logic [19:0]     len;
		logic [23:0]     pkt_len;
		logic [7:0]      opts;
		logic            pkt_start;
		logic            pkt_end;
		logic            vlan_ins;
		logic [15:0]     vlan_tag;
		logic            fcs;
		logic            seg;
		logic            enable;
		logic            vlan_mode;
		logic [3:0]      stat;
		logic [3:0]      mask;
		logic [15:0]     delay;
		logic [19:0]     fifo_alloc;
		logic [15:0]     etype;
		logic            ack;
		logic [31:0]     rdata;
	} state_t;
	state_t q, d;

	desc_fields_if f ();
	logic timer_fire;
	logic timer_load;
	logic timer_clear;
	logic desc_take;
	logic fetch_take;
	logic wback_take;
	logic bus_req;
	logic bus_wr;
	logic [3:0] ev;
	logic [3:0] w1c;
	logic [23:0] sum;

	desc_unpack u_unpack (
		.desc_i (desc_data_i),
		.f      (f)
	);

	delay_timer #(.CNT_W(16)) u_timer (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.load_i   (timer_load),
		.clear_i  (timer_clear),
		.reload_i (q.delay),
		.expire_o (timer_fire)
	);

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (sel[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// ---------------------------------------------
	// handshakes
	// ---------------------------------------------
	assign desc_ready_o = (q.phase == txd_pkg::ST_IDLE) && q.enable;
	assign desc_take = desc_valid_i && desc_ready_o;
	assign fetch_take = fetch_valid_o && fetch_ready_i;
	assign wback_take = wback_valid_o && wback_ready_i;
	// status only for report-status descriptors [R10]
	assign wback_status_o = txd_pkg::STATUS_DONE;
	// delay enabled reloads, otherwise immediate and cleared [R11]
	assign timer_load = wback_take && q.cmd[txd_pkg::CMD_DELAY];
	assign timer_clear = wback_take && !q.cmd[txd_pkg::CMD_DELAY];
	// write takes effect on the edge that sees ack
	assign bus_req = wb_cyc_i && wb_stb_i;
	assign bus_wr = bus_req && wb_we_i && q.ack;
	// running packet sum including this descriptor [R13]
	assign sum = (q.in_pkt ? q.pkt_len : 24'h00_0000) + {4'h0, f.len};

	always_comb begin
		ev = 4'h0;
		ev[txd_pkg::INT_DONE] = timer_fire || timer_clear; // [R11]
		ev[txd_pkg::INT_BAD] = desc_take && !f.is_data; // [R9]
		// host limit check; flagged, not enforced [R3]
		ev[txd_pkg::INT_LEN] = desc_take && f.is_data && !f.cmd[txd_pkg::CMD_SEG] &&
			(sum + txd_pkg::FIFO_MARGIN > {4'h0, q.fifo_alloc});
		ev[txd_pkg::INT_PKT] = desc_take && f.is_data && f.cmd[txd_pkg::CMD_END];
		w1c = 4'h0;
		if (bus_wr && wb_adr_i == txd_pkg::REG_STATUS && wb_sel_i[0]) begin
			w1c = wb_dat_i[3:0];
		end
	end

	// ---------------------------------------------
	// next state
	// ---------------------------------------------
	always_comb begin
		d = q;
		d.pkt_start = 1'b0;
		d.pkt_end = 1'b0;
		// set wins over clear
		d.stat = (q.stat & ~w1c) | ev;
		unique case (q.phase)
			txd_pkg::ST_IDLE: begin
				if (desc_take && f.is_data) begin // [R4]
					d.addr = f.addr; // [R1]
					d.len = f.len; // [R2]
					d.cmd = f.cmd; // [R8]
					d.pkt_len = sum;
					if (!q.in_pkt) begin
						d.opts = f.opts; // [R6]
						d.seg = f.cmd[txd_pkg::CMD_SEG];
						d.pkt_start = 1'b1;
					end
					d.in_pkt = !f.cmd[txd_pkg::CMD_END]; // [R13]
					if (f.cmd[txd_pkg::CMD_END]) begin
						d.pkt_end = 1'b1;
						d.vlan_tag = f.special; // [R7]
						d.vlan_ins = f.cmd[txd_pkg::CMD_VLAN] && q.vlan_mode; // [R12]
						d.fcs = f.cmd[txd_pkg::CMD_FCS] || d.vlan_ins; // [R12]
					end
					d.phase = txd_pkg::ST_FETCH;
				end
			end
			txd_pkg::ST_FETCH: begin
				if (fetch_take) begin
					d.phase = q.cmd[txd_pkg::CMD_REPORT] ? txd_pkg::ST_WBACK
						: txd_pkg::ST_IDLE; // [R10]
				end
			end
			txd_pkg::ST_WBACK: begin
				if (wback_take) begin
					d.phase = txd_pkg::ST_IDLE;
				end
			end
			default: begin
				d.phase = txd_pkg::ST_IDLE;
			end
		endcase
		// bus: ack one cycle after request, dropped the cycle after
		d.ack = bus_req && !q.ack;
		d.rdata = 32'h0000_0000;
		if (bus_req && !q.ack && !wb_we_i) begin
			unique case (wb_adr_i)
				txd_pkg::REG_CTRL: d.rdata = {30'h0000_0000, q.vlan_mode, q.enable};
				txd_pkg::REG_STATUS: d.rdata = {28'h000_0000, q.stat};
				txd_pkg::REG_MASK: d.rdata = {28'h000_0000, q.mask};
				txd_pkg::REG_DELAY: d.rdata = {16'h0000, q.delay};
				txd_pkg::REG_FIFO: d.rdata = {12'h000, q.fifo_alloc};
				txd_pkg::REG_ETYPE: d.rdata = {16'h0000, q.etype};
				txd_pkg::REG_PKT: d.rdata = {q.in_pkt, q.phase, 5'h00, q.pkt_len};
				default: d.rdata = 32'h0000_0000;
			endcase
		end
		if (bus_wr) begin
			unique case (wb_adr_i)
				txd_pkg::REG_CTRL: begin
					d.enable = wb_sel_i[0] ? wb_dat_i[0] : q.enable;
					d.vlan_mode = wb_sel_i[0] ? wb_dat_i[1] : q.vlan_mode;
				end
				txd_pkg::REG_MASK: d.mask = wb_sel_i[0] ? wb_dat_i[3:0] : q.mask;
				txd_pkg::REG_DELAY: d.delay = 16'(merge({16'h0000, q.delay}, wb_dat_i, wb_sel_i));
				txd_pkg::REG_FIFO: d.fifo_alloc = 20'(merge({12'h000, q.fifo_alloc}, wb_dat_i,
					wb_sel_i));
				txd_pkg::REG_ETYPE: d.etype = 16'(merge({16'h0000, q.etype}, wb_dat_i, wb_sel_i));
				default: d.enable = q.enable;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			q <= '0;
			q.fifo_alloc <= txd_pkg::FIFO_RST;
			q.etype <= txd_pkg::ETYPE_RST;
			q.delay <= txd_pkg::DELAY_RST;
		end else begin
			q <= d;
		end
	end

	// ---------------------------------------------
	// outputs
	// ---------------------------------------------
	assign wb_ack_o = q.ack;
	assign wb_dat_o = q.rdata;
	assign fetch_valid_o = (q.phase == txd_pkg::ST_FETCH);
	assign fetch_addr_o = q.addr;
	assign fetch_len_o = q.len;
	assign wback_valid_o = (q.phase == txd_pkg::ST_WBACK);
	assign pkt_start_o = q.pkt_start;
	assign opts_o = q.opts;
	assign pkt_end_o = q.pkt_end;
	assign vlan_insert_o = q.vlan_ins;
	assign vlan_tag_o = q.vlan_tag;
	assign vlan_etype_o = q.etype;
	assign append_fcs_o = q.fcs;
	assign seg_o = q.seg;
	assign irq_o = |(q.stat & q.mask);

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_fetch_hold: assert property (fetch_valid_o && !fetch_ready_i |=> // [R1]
		fetch_valid_o && $stable(fetch_addr_o))
		else $error("fetch request dropped or changed");
	a_fetch_len: assert property (desc_take && f.is_data |=> // [R2]
		fetch_valid_o && fetch_len_o == $past(f.len))
		else $error("fetch length differs from descriptor");
	a_type_reject: assert property (desc_take && !f.is_data |=> // [R4]
		!fetch_valid_o && q.stat[txd_pkg::INT_BAD])
		else $error("bad descriptor not rejected");
	a_fetch_addr: assert property (desc_take && f.is_data |=> // [R1]
		fetch_addr_o == $past(f.addr))
		else $error("fetch address differs from descriptor");
	// rejected descriptors free the slot at once
	a_bad_ready: assert property (desc_take && !f.is_data |=> desc_ready_o) // [R9]
		else $error("slot not freed after rejected descriptor");
	a_opts_first: assert property (desc_take && f.is_data && !q.in_pkt |=> // [R6]
		pkt_start_o && opts_o == $past(f.opts))
		else $error("options not taken from first descriptor");
	a_opts_later: assert property (desc_take && f.is_data && q.in_pkt |=> // [R6]
		$stable(opts_o) && !pkt_start_o)
		else $error("options taken from later descriptor");
	a_vlan_end: assert property (desc_take && f.is_data && !f.cmd[txd_pkg::CMD_END] |=> // [R7]
		$stable(vlan_tag_o) && !pkt_end_o)
		else $error("vlan tag taken without end of packet");
	a_end_close: assert property (desc_take && f.is_data && f.cmd[txd_pkg::CMD_END] |=> // [R13]
		pkt_end_o && !q.in_pkt)
		else $error("end of packet not closed");
	a_wback_report: assert property (wback_valid_o |-> q.cmd[txd_pkg::CMD_REPORT] && // [R10]
		wback_status_o[0])
		else $error("writeback without report status");
	a_irq_now: assert property (wback_take && !q.cmd[txd_pkg::CMD_DELAY] |=> // [R11]
		q.stat[txd_pkg::INT_DONE])
		else $error("immediate interrupt missing");
	// expiry and immediate completion share the done bit
	a_done_set: assert property (timer_fire |=> q.stat[txd_pkg::INT_DONE]) // [R11]
		else $error("timer expiry not flagged");
	a_vlan_fcs: assert property (pkt_end_o && vlan_insert_o |-> append_fcs_o) // [R12]
		else $error("vlan insert without fcs append");
	a_len_flag: assert property (ev[txd_pkg::INT_LEN] |=> q.stat[txd_pkg::INT_LEN]) // [R3]
		else $error("length overrun not flagged");

	// multi-descriptor packet, delayed completion, expiry, reject, overrun
	c_packet: cover property (desc_take ##1 pkt_start_o ##[1:20] pkt_end_o);
	c_wback: cover property (wback_take && q.cmd[txd_pkg::CMD_DELAY]);
	c_timer: cover property (timer_fire);
	c_bad: cover property (desc_take && !f.is_data);
	c_len: cover property (ev[txd_pkg::INT_LEN]);
endmodule

// >>> sim/host_desc_model.sv
// Purpose: host side model that offers descriptors and accepts fetch and writeback
// Assumes: one descriptor in flight, core clock
// Notes:   random stalls on both accept paths
`timescale 1ns/1ps
module host_desc_model (
	// clock and reset
	input  wire logic    clk_i,
	input  wire logic    rst_i,
	// descriptor stream
	input  wire logic    desc_ready_i,
	output logic         desc_valid_o,
	output logic [127:0] desc_data_o,
	// fetch and writeback
	input  wire logic    fetch_valid_i,
	output logic         fetch_ready_o,
	input  wire logic    wback_valid_i,
	output logic         wback_ready_o
);
	int seed;
	initial begin
		seed = 8105;
		desc_valid_o = 1'b0;
		desc_data_o = '0;
		fetch_ready_o = 1'b0;
		wback_ready_o = 1'b0;
	end
	// ------------------------------------------
	// stalling consumers
	// ------------------------------------------
	always @(posedge clk_i) begin
		fetch_ready_o <= !rst_i && fetch_valid_i && !fetch_ready_o && ($random(seed) % 2 == 0);
		wback_ready_o <= !rst_i && wback_valid_i && !wback_ready_o && ($random(seed) % 2 == 0);
	end
	// ------------------------------------------
	// descriptor build and offer
	// ------------------------------------------
	function automatic logic [127:0] mk(input logic [63:0] a, input logic [19:0] n,
		input logic [3:0] t, input logic [7:0] c, input logic [7:0] o, input logic [15:0] s);
		mk = {s, o, 4'h0, 4'h0, c, t, n, a};
	endfunction
	task automatic send(input logic [127:0] d, output bit ok);
		int i;
		@(posedge clk_i);
		desc_valid_o <= 1'b1;
		desc_data_o <= d;
		ok = 1'b0;
		for (i = 0; i < 100 && !ok; i++) begin
			@(posedge clk_i);
			ok = desc_ready_i;
		end
		// released data must not look valid
		desc_valid_o <= 1'b0;
		desc_data_o <= ~d;
	endtask
endmodule

// >>> sim/tx_desc_decode_test.sv
// Purpose: self-checking bench for the transmit descriptor decoder
// Assumes: registers reached by classic Wishbone single cycles
// Notes:   random packets of one to three descriptors plus corner cases
`timescale 1ns/1ps
module tx_desc_decode_test;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, desc_valid_i, desc_ready_o;
	logic fetch_valid_o, fetch_ready_i, wback_valid_o, wback_ready_i, pkt_start_o, pkt_end_o;
	logic vlan_insert_o, append_fcs_o, seg_o, irq_o;
	logic [7:0]   wb_adr_i, opts_o;
	logic [3:0]   wb_sel_i, wback_status_o;
	logic [31:0]  wb_dat_i, wb_dat_o, q;
	logic [127:0] desc_data_i;
	logic [63:0]  fetch_addr_o, f_addr, x_addr;
	logic [19:0]  fetch_len_o, f_len, n;
	logic [15:0]  vlan_tag_o, vlan_etype_o, e_tag, s;
	logic [7:0]   s_opts, c, o, o0, c0;
	logic [3:0]   w_stat;
	logic         e_vins, e_fcs, s_seg;
	int seed, miscompares, checks, n_fetch, n_wb, n_start, n_end, p, j, k, nf, nw;
	bit ok;
	tx_desc_decode u_tx_desc_decode (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.desc_valid_i(desc_valid_i), .desc_data_i(desc_data_i), .desc_ready_o(desc_ready_o),
		.fetch_valid_o(fetch_valid_o), .fetch_addr_o(fetch_addr_o), .fetch_len_o(fetch_len_o),
		.fetch_ready_i(fetch_ready_i), .wback_valid_o(wback_valid_o),
		.wback_status_o(wback_status_o), .wback_ready_i(wback_ready_i),
		.pkt_start_o(pkt_start_o), .opts_o(opts_o), .pkt_end_o(pkt_end_o),
		.vlan_insert_o(vlan_insert_o), .vlan_tag_o(vlan_tag_o), .vlan_etype_o(vlan_etype_o),
		.append_fcs_o(append_fcs_o), .seg_o(seg_o), .irq_o(irq_o));
	host_desc_model u_host_desc_model (.clk_i(clk_i), .rst_i(rst_i),
		.desc_ready_i(desc_ready_o), .desc_valid_o(desc_valid_i), .desc_data_o(desc_data_i),
		.fetch_valid_i(fetch_valid_o), .fetch_ready_o(fetch_ready_i),
		.wback_valid_i(wback_valid_o), .wback_ready_o(wback_ready_i));
	initial begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	// ------------------------------------------
	// output monitor
	// ------------------------------------------
	always @(posedge clk_i) begin
		if (fetch_valid_o && fetch_ready_i) begin
			n_fetch++;
			f_addr = fetch_addr_o;
			f_len = fetch_len_o;
		end
		if (wback_valid_o && wback_ready_i) begin
			n_wb++;
			w_stat = wback_status_o;
		end
		if (pkt_start_o) begin
			n_start++;
			s_opts = opts_o;
			s_seg = seg_o;
		end
		if (pkt_end_o) begin
			n_end++;
			e_tag = vlan_tag_o;
			e_vins = vlan_insert_o;
			e_fcs = append_fcs_o;
		end
	end
	// ------------------------------------------
	// tasks and expectations
	// ------------------------------------------
	function automatic logic exp_fcs(input logic [7:0] cmd);
		exp_fcs = cmd[txd_pkg::CMD_FCS] | cmd[txd_pkg::CMD_VLAN];
	endfunction
	task automatic test_done();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stuck();
		miscompares++;
		test_done();
	endtask
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		for (i = 0; i < 50 && wb_ack_o !== 1'b1; i++)
			@(posedge clk_i);
		if (i == 50)
			stuck();
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		wb(1'b0, a, 32'h0000_0000);
		chk($sformatf("reg %h", a), q & m, e);
	endtask
	task automatic put(input logic [127:0] d);
		int i;
		u_host_desc_model.send(d, ok);
		if (!ok)
			stuck();
		// ready still shows idle at the taking edge
		@(posedge clk_i);
		for (i = 0; i < 100 && desc_ready_o !== 1'b1; i++)
			@(posedge clk_i);
		if (i == 100)
			stuck();
	endtask
	// ------------------------------------------
	// main sequence
	// ------------------------------------------
	initial begin
		seed = 8105;
		{miscompares, checks, n_fetch, n_wb, n_start, n_end} = '0;
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
		wb_sel_i = 4'hF;
		rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		rchk(txd_pkg::REG_FIFO, 32'hFFFF_FFFF, {12'h000, txd_pkg::FIFO_RST});
		rchk(txd_pkg::REG_ETYPE, 32'hFFFF_FFFF, {16'h0000, txd_pkg::ETYPE_RST});
		rchk(8'h40, 32'hFFFF_FFFF, 32'h0000_0000);
		wb(1'b1, txd_pkg::REG_CTRL, 32'h0000_0003);
		wb(1'b1, txd_pkg::REG_MASK, 32'h0000_000F);
		for (p = 0; p < 30; p++) begin
			k = 1 + $unsigned($random(seed)) % 3;
			for (j = 0; j < k; j++) begin
				// short lengths keep each packet clear of the fifo margin
				n = 20'($random(seed)) & 20'h0_03FF;
				c = (8'($random(seed)) & 8'h4E) | 8'h20 | 8'(j == k - 1);
				o = 8'($random(seed));
				s = 16'($random(seed));
				if (j == 0) begin
					o0 = o;
					c0 = c;
				end
				{nf, nw} = {n_fetch, n_wb};
				x_addr = {$random(seed), $random(seed)};
				put(u_host_desc_model.mk(x_addr, n, txd_pkg::TYPE_DATA, c, o, s));
				chk("addr", f_addr, x_addr);
				chk("len", f_len, n);
				chk("fetches", n_fetch, nf + 1);
				chk("wbacks", n_wb, nw + c[txd_pkg::CMD_REPORT]);
				if (c[txd_pkg::CMD_REPORT])
					chk("status", w_stat, txd_pkg::STATUS_DONE);
			end
			chk("opts", s_opts, o0);
			chk("seg", s_seg, c0[txd_pkg::CMD_SEG]);
			chk("tag", e_tag, s);
			chk("vins", e_vins, c[txd_pkg::CMD_VLAN]);
			chk("fcs", e_fcs, exp_fcs(c));
			chk("pkts", {n_start, n_end}, {p + 1, p + 1});
		end
		chk("etype", vlan_etype_o, 16'h8100);
		chk("irq", irq_o, 1'b1);
		rchk(txd_pkg::REG_STATUS, 32'h0000_0004, 32'h0000_0000);
		wb(1'b1, txd_pkg::REG_STATUS, 32'h0000_000F);
		rchk(txd_pkg::REG_STATUS, 32'h0000_000F, 32'h0000_0000);
		nf = n_fetch;
		put(u_host_desc_model.mk(64'h0, 20'h0_0010, txd_pkg::TYPE_DATA, 8'h01, 8'h0, 16'h0));
		put(u_host_desc_model.mk(64'h0, 20'h0_0010, 4'h2, 8'h21, 8'h0, 16'h0));
		chk("bad fetch", n_fetch, nf);
		rchk(txd_pkg::REG_STATUS, 32'h0000_0002, 32'h0000_0002);
		wb(1'b1, txd_pkg::REG_STATUS, 32'h0000_000F);
		put(u_host_desc_model.mk(64'h80, 20'h0_0008, txd_pkg::TYPE_DATA, 8'h29, 8'h0, 16'h0));
		rchk(txd_pkg::REG_STATUS, 32'h0000_0001, 32'h0000_0001);
		wb(1'b1, txd_pkg::REG_STATUS, 32'h0000_000F);
		wb(1'b1, txd_pkg::REG_DELAY, 32'h0000_0028);
		put(u_host_desc_model.mk(64'h100, 20'h0_0040, txd_pkg::TYPE_DATA, 8'hA9, 8'h0, 16'h0));
		rchk(txd_pkg::REG_STATUS, 32'h0000_0001, 32'h0000_0000);
		repeat (45) @(posedge clk_i);
		rchk(txd_pkg::REG_STATUS, 32'h0000_0001, 32'h0000_0001);
		wb(1'b1, txd_pkg::REG_MASK, 32'h0000_0000);
		// mask lands on the acknowledging edge; look one cycle on
		@(posedge clk_i);
		chk("irq masked", irq_o, 1'b0);
		wb(1'b1, txd_pkg::REG_CTRL, 32'h0000_0001);
		put(u_host_desc_model.mk(64'h300, 20'h0_0020, txd_pkg::TYPE_DATA, 8'h61, 8'h0, 16'h0));
		chk("vins off", e_vins, 1'b0);
		chk("fcs off", e_fcs, 1'b0);
		wb(1'b1, txd_pkg::REG_FIFO, 32'h0000_0064);
		// thirty bytes plus the margin overruns a hundred byte allocation
		put(u_host_desc_model.mk(64'h200, 20'h0_001E, txd_pkg::TYPE_DATA, 8'h21, 8'h0, 16'h0));
		rchk(txd_pkg::REG_STATUS, 32'h0000_0004, 32'h0000_0004);
		test_done();
	end
endmodule
